// >>> hdl/multibit_serial_io_transfer.sv
/*
 sequencer for multi-bit transfers on a bit-addressed serial i/o bus.
 a load shifts bits of a word out to successive bit addresses; a store
 gathers bits from successive addresses into a word.
 assumes the i/o device answers combinationally on serial_input_line
 (synchronised here) and captures serial_output_line on the strobe.
*/
`timescale 1ns/10ps
module multibit_serial_io_transfer
   import serial_io_pkg::*;
#(
   parameter int SAMPLE_WAIT = 2
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic store_op,
   input wire logic [CNT_W-1:0] count,
   input wire logic [WORD_W-1:0] base_pointer_register,
   input wire logic [WORD_W-1:0] data_in,
   input wire logic serial_input_line,
   output logic busy,
   output logic done,
   output logic [WORD_W-1:0] data_out,
   output logic [ADDR_W-1:0] bit_address,
   output logic serial_output_line,
   output logic output_bit_strobe
);
   import serial_io_pkg::*;

   typedef enum logic [1:0] {idle, load_bit, store_wait, finish} state_e;

   // refuse wait counts the synchroniser or wait_cnt cannot serve
   if (SAMPLE_WAIT < 2 || SAMPLE_WAIT > 7) begin : g_bad_wait
      $error("SAMPLE_WAIT must cover the two-stage synchroniser");
   end

   state_e state;
   logic [3:0] step;
   logic [2:0] wait_cnt;
   logic [CNT_BITS_W-1:0] nbits;
   logic byte_mode;
   logic [WORD_W-1:0] src;
   logic [WORD_W-1:0] old_word;
   logic [WORD_W-1:0] shifted;
   logic in_meta;
   logic in_sync;
   logic [3:0] pos;
   logic [WORD_W-1:0] result;
   logic last_bit;
   logic store_op_q;

   // word bit for the step, and zero-filled store result
   bit_place u_place (
      .byte_mode(byte_mode),
      .step(step),
      .nbits(nbits),
      .shifted(shifted),
      .old_word(old_word),
      .pos(pos),
      .result(result)
   );

   assign last_bit = ({1'b0, step} == nbits - 5'h01);
   assign busy = (state != idle);

   // two-flop synchroniser on the serial input pin
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_meta <= 1'b0;
         in_sync <= 1'b0;
      end else begin
         in_meta <= serial_input_line;
         in_sync <= in_meta;
      end
   end

   // sequencer state and step counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= idle;
         step <= 4'h0;
         wait_cnt <= 3'h0;
      end else begin
         case (state)
            idle: begin
               step <= 4'h0;
               wait_cnt <= 3'h0;
               if (start) begin
                  state <= store_op ? store_wait : load_bit;
               end
            end
            load_bit: begin
               if (last_bit) begin
                  state <= finish;
               end
               step <= step + 4'h1;
            end
            store_wait: begin
               if (wait_cnt == 3'(SAMPLE_WAIT)) begin
                  wait_cnt <= 3'h0;
                  step <= step + 4'h1;
                  if (last_bit) begin
                     state <= finish;
                  end
               end else begin
                  wait_cnt <= wait_cnt + 3'h1;
               end
            end
            finish: begin
               state <= idle;
            end
            default: begin
               state <= idle;
            end
         endcase
      end
   end

   // latch transfer parameters at start
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nbits <= FULL_BITS;
         byte_mode <= 1'b0;
         src <= 16'h0000;
         old_word <= 16'h0000;
      end else if (state == idle && start) begin
         nbits <= (count == CNT_ALL) ? FULL_BITS : {1'b0, count};
         byte_mode <= (count != CNT_ALL) && ({1'b0, count} <= BYTE_BITS);
         // lsb-0 internally; msb-0 bit 15 is index 0
         src <= data_in;
         old_word <= data_in;
      end
   end

   // bit address: pointer bits 4..14, incremented per bit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bit_address <= 11'h000;
      end else if (state == idle && start) begin
         bit_address <= base_pointer_register[BASE_HI:BASE_LO];
      end else if (state == load_bit) begin
         // step after first
         // the address moves with the strobe, so the first bit sent
         // still meets the base address at the far side
         if (step != 4'h0) begin
            bit_address <= bit_address + 11'h001;
         end
      end else if (state == store_wait &&
                   wait_cnt == 3'(SAMPLE_WAIT)) begin
         if (!last_bit) begin
            bit_address <= bit_address + 11'h001;
         end
      end
   end

   // load output: data and strobe per bit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         serial_output_line <= 1'b0;
         output_bit_strobe <= 1'b0;
      end else if (state == load_bit) begin
         serial_output_line <= src[pos];
         output_bit_strobe <= 1'b1;
      end else begin
         output_bit_strobe <= 1'b0;
      end
   end

   // gather store bits, first into lowest position
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shifted <= 16'h0000;
      end else if (state == idle) begin
         shifted <= 16'h0000;
      end else if (state == store_wait &&
                   wait_cnt == 3'(SAMPLE_WAIT)) begin
         shifted[step] <= in_sync;
      end
   end

   // result word and completion pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         data_out <= 16'h0000;
         done <= 1'b0;
      end else if (state == finish) begin
         done <= 1'b1;
         data_out <= store_op_q ? result : old_word;
      end else begin
         done <= 1'b0;
      end
   end

   // remember the operation kind for the result mux
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         store_op_q <= 1'b0;
      end else if (state == idle && start) begin
         store_op_q <= store_op;
      end
   end
endmodule

// >>> hdl/serial_io_pkg.sv
/*
 package for the multi-bit serial i/o transfer sequencer: widths, field
 positions and counts shared by the sequencer and its bit selector.
 assumes nothing of its surroundings.
*/
package serial_io_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 11;
   localparam int CNT_W = 4;
   localparam int CNT_BITS_W = 5;
   // base pointer bits 4..14 (bit 0 msb) are word bits 11..1 (lsb 0)
   localparam int BASE_LO = 1;
   localparam int BASE_HI = 11;
   localparam logic [CNT_W-1:0] CNT_ALL = 4'h0;
   localparam logic [CNT_BITS_W-1:0] FULL_BITS = 5'h10;
   localparam logic [CNT_BITS_W-1:0] BYTE_BITS = 5'h08;
   // first bit of a byte transfer, counted from the lsb end
   localparam logic [3:0] BYTE_START = 4'h8;
   localparam logic [3:0] WORD_START = 4'h0;
endpackage

// >>> hdl/bit_place.sv
/*
 bit selector: maps a transfer step to the word bit it touches, and
 builds the zero-filled store result from the gathered bits.
 assumes the step index stays below the decoded bit count.
*/
`timescale 1ns/10ps
module bit_place
   import serial_io_pkg::*;
(
   input wire logic byte_mode,
   input wire logic [3:0] step,
   input wire logic [CNT_BITS_W-1:0] nbits,
   input wire logic [WORD_W-1:0] shifted,
   input wire logic [WORD_W-1:0] old_word,
   output logic [3:0] pos,
   output logic [WORD_W-1:0] result
);
   import serial_io_pkg::*;

   // lsb-numbered index of the bit for this step
   // byte start bit
   always_comb begin
      pos = (byte_mode ? BYTE_START : WORD_START) + step;
   end

   // merge gathered bits, clearing unused upper bits
   // zero fill
   genvar i;
   generate
      for (i = 0; i < WORD_W; i++) begin : g_bit
         if (i < 8) begin : g_low
            // low byte (bits 8..15 in msb-0 order) kept on a byte store
            // low byte kept
            assign result[i] = byte_mode ? old_word[i] :
               ((i < nbits) ? shifted[i] : 1'b0);
         end else begin : g_high
            assign result[i] = byte_mode ?
               (((i - 8) < nbits) ? shifted[i - 8] : 1'b0) :
               ((i < nbits) ? shifted[i] : 1'b0);
         end
      end
   endgenerate
endmodule

// >>> testbench/xfer_checker.sv
/*
 port checker for the multi-bit transfer sequencer.
 assumes binding to the sequencer's top module ports.
*/
`timescale 1ns/10ps
module xfer_checker
   import serial_io_pkg::*;
#(
   parameter int SAMPLE_WAIT = 2
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic store_op,
   input wire logic [CNT_W-1:0] count,
   input wire logic [WORD_W-1:0] base_pointer_register,
   input wire logic [WORD_W-1:0] data_in,
   input wire logic serial_input_line,
   input wire logic busy,
   input wire logic done,
   input wire logic [WORD_W-1:0] data_out,
   input wire logic [ADDR_W-1:0] bit_address,
   input wire logic serial_output_line,
   input wire logic output_bit_strobe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // load and store requests taken in idle
   wire ld = start && !busy && !store_op;
   wire st = start && !busy && store_op;
   // relations between requests and outputs
   a_strobe_busy: assert property (output_bit_strobe |-> busy)
      else $error("strobe while idle");
   a_done_pulse: assert property (done |=> !done)
      else $error("done held too long");
   a_first_addr: assert property (ld |-> ##2 output_bit_strobe &&
      bit_address == $past(base_pointer_register[11:1], 2))
      else $error("bad start address");
   a_word_lsb: assert property (ld && count == 0 |-> ##2
      serial_output_line == $past(data_in[0], 2))
      else $error("bad first word bit");
   a_byte_bit7: assert property (ld && count != 0 && count <= 8 |-> ##2
      serial_output_line == $past(data_in[8], 2))
      else $error("bad first byte bit");
   a_addr_step: assert property (output_bit_strobe ##1 output_bit_strobe |->
      bit_address == $past(bit_address) + 11'h001)
      else $error("address not stepped");
   a_full_load: assert property (ld && count == 0 |-> ##18 done)
      else $error("full load length wrong");
   a_store_quiet: assert property (st |=> !output_bit_strobe [*5])
      else $error("strobe during store");
   a_store_ends: assert property (st |-> ##[5:200] done)
      else $error("store never ends");
   c_word_load: cover property (ld && count == 0);
   c_byte_store: cover property (st && count == 4);
   c_store_done: cover property (st ##[5:200] done);
endmodule

// >>> testbench/io_bit_device.sv
/*
 i/o device model: a bit array addressed by bit_address.
 assumes the sequencer's clock; answers reads at once.
*/
`timescale 1ns/10ps
module io_bit_device
   import serial_io_pkg::*;
(
   input wire logic clk,
   input wire logic [ADDR_W-1:0] bit_address,
   input wire logic serial_output_line,
   input wire logic output_bit_strobe,
   output logic serial_input_line
);
   logic [2047:0] mem = '0;
   always_ff @(posedge clk) begin
      if (output_bit_strobe) begin
         mem[bit_address] <= serial_output_line;
      end
   end
   // addressed bit answered combinationally
   assign serial_input_line = mem[bit_address];
endmodule

// >>> testbench/tb_multibit_serial_io_transfer.sv
/*
 testbench: loads and stores against a bit array model.
 assumes the sequencer, its package and the checker.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_multibit_serial_io_transfer;
   import serial_io_pkg::*;
   logic clk = 0, nrst = 0, start = 0, store_op = 0, sin;
   logic [3:0] count = 0;
   logic [15:0] bp = 0, din = 0, dout, q;
   logic busy, done, sout, strobe;
   logic [10:0] addr;
   int n_fail = 0, comparisons = 0, n_strobe = 0;
   multibit_serial_io_transfer i_multibit_serial_io_transfer (.clk(clk),
      .nrst(nrst), .start(start), .store_op(store_op), .count(count),
      .base_pointer_register(bp), .data_in(din), .serial_input_line(sin),
      .busy(busy), .done(done), .data_out(dout), .bit_address(addr),
      .serial_output_line(sout), .output_bit_strobe(strobe));
   io_bit_device i_io_bit_device (.clk(clk), .bit_address(addr),
      .serial_output_line(sout), .output_bit_strobe(strobe),
      .serial_input_line(sin));
   // clock and strobe counter
   always #20 clk = ~clk;
   always @(posedge clk) if (strobe === 1'b1) n_strobe++;
   task complete_run;
      if (n_fail == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // one transfer, waits for done under a bound
   task xfer(input logic s, input logic [3:0] c, input logic [15:0] b, d);
      int k;
      @(posedge clk); #1;
      start = 1; store_op = s; count = c; bp = b; din = d; n_strobe = 0;
      @(posedge clk); #1;
      start = 0;
      k = 0;
      while (done !== 1'b1 && k < 200) begin @(posedge clk); #1; k++; end
      `CHK(done, 1'b1)
      q = dout;
      while (busy !== 1'b0 && k < 300) begin @(posedge clk); #1; k++; end
   endtask
   task test_counts;
      for (int c = 0; c < 16; c++) begin
         xfer(0, c[3:0], 16'h0100, 16'hA5C3);
         `CHK(n_strobe, (c == 0) ? 16 : c)
      end
   endtask
   task test_word;
      logic [15:0] pat;
      pat = 16'hB95B;
      xfer(0, 4'h0, 16'h0020, pat);
      `CHK(q, 16'hB95B)
      for (int i = 0; i < 16; i++) `CHK(i_io_bit_device.mem[16+i], pat[i])
      `CHK(i_io_bit_device.mem[31:16], 16'hB95B)
      xfer(1, 4'h0, 16'h0020, 16'h1234);
      `CHK(q, 16'hB95B)
      xfer(1, 4'h9, 16'h0020, 16'hFFFF);
      `CHK(q, 16'h015B)
   endtask
   task test_byte;
      xfer(0, 4'h4, 16'h0040, 16'hB6B5);
      `CHK(i_io_bit_device.mem[35:32], 4'h6)
      xfer(1, 4'h4, 16'h0040, 16'hC3FF);
      `CHK(q, 16'h06FF)
      xfer(1, 4'h8, 16'h0040, 16'h00AA);
      `CHK(q, 16'h06AA)
   endtask
   // cut a full load by reset, then store what reached the far side
   task test_reset;
      @(posedge clk); #1;
      start = 1; store_op = 0; count = 4'h0; bp = 16'h0060; din = 16'hFFFF;
      @(posedge clk); #1;
      start = 0;
      repeat (4) @(posedge clk);
      #1;
      `CHK(busy, 1'b1)
      `CHK(strobe, 1'b1)
      nrst = 0;
      #1;
      `CHK({busy, done, strobe, sout}, 4'h0)
      `CHK(dout, 16'h0000)
      `CHK(addr, 11'h000)
      repeat (2) @(posedge clk);
      #1 nrst = 1;
      xfer(1, 4'h2, 16'h0060, 16'hFFFF);
      `CHK(q, 16'h03FF)
   endtask
   // reset, scenarios, verdict
   initial begin
      repeat (10) @(posedge clk);
      #1 nrst = 1;
      test_counts;
      test_word;
      test_byte;
      test_reset;
      complete_run;
   end
   initial begin
      #200000;
      n_fail++;
      complete_run;
   end
endmodule
bind multibit_serial_io_transfer xfer_checker #(.SAMPLE_WAIT(SAMPLE_WAIT))
   i_xfer_checker (.clk(clk), .nrst(nrst), .start(start),
   .store_op(store_op), .count(count),
   .base_pointer_register(base_pointer_register), .data_in(data_in),
   .serial_input_line(serial_input_line), .busy(busy), .done(done),
   .data_out(data_out), .bit_address(bit_address),
   .serial_output_line(serial_output_line),
   .output_bit_strobe(output_bit_strobe));
